// >>> logic/ctrsr_defines.svh
`ifndef CTRSR_DEFINES_SVH
`define CTRSR_DEFINES_SVH

// Register word indices (one word per address)
`define CTRSR_REG_SELA 4'h0
`define CTRSR_REG_SELB 4'h1
`define CTRSR_REG_MODE 4'h2
`define CTRSR_REG_CNT 4'h3
`define CTRSR_CTR_STRIDE 4'h4
`define CTRSR_REG_PFI_LO 4'h8
`define CTRSR_REG_PFI_HI 4'h9
`define CTRSR_REG_TRUNK 4'ha
`define CTRSR_REG_CMD 4'hb
`define CTRSR_REG_STATUS 4'hc
`define CTRSR_REG_SQW 4'hd

// Command bits
`define CTRSR_CMD_ARM 0
`define CTRSR_CMD_DISARM 2

// Selector field width and spacing inside a select register, and route field width
`define CTRSR_CODE_W 6
`define CTRSR_SEL_FIELD 8
`define CTRSR_ROUTE_W 3

// Source index map of the selector vector
`define CTRSR_SRC_TRUNK 0
`define CTRSR_SRC_PFI 8
`define CTRSR_SRC_ACQ_REF 24
`define CTRSR_SRC_ACQ_START 25
`define CTRSR_SRC_STAR 31
`define CTRSR_SRC_CMP 33
`define CTRSR_SRC_OTHER_OUT 34
`define CTRSR_SRC_OTHER_SRC 35
`define CTRSR_SRC_OTHER_GATE 36
`define CTRSR_SRC_OWN_GATE 37
`define CTRSR_NSRC 38

// Allowed-source masks per selector kind
`define CTRSR_MASK_GATE 38'h0f_ffff_ffff
`define CTRSR_MASK_AUX 38'h3e_83ff_ffff
`define CTRSR_MASK_ARM 38'h06_83ff_ffff
`define CTRSR_MASK_ABZ 38'h02_80ff_ffff

// Output route codes
`define CTRSR_RT_OFF 3'h0
`define CTRSR_RT_GATE0 3'h1
`define CTRSR_RT_Z0 3'h5
`define CTRSR_RT_SQW 3'h5

// Reset values
`define CTRSR_RST_MODE 8'h00
`define CTRSR_RST_CNT 32'h0000_0001

`endif

// >>> logic/ctrsr_pkg.sv
package ctrsr_pkg;
  typedef logic [5:0] ctrsr_code_t;
  typedef logic [2:0] ctrsr_route_t;

  // Per-counter mode word, bit 7 first
  typedef struct packed {
    logic pause_level;
    logic pause_en;
    logic retrig;
    logic finite;
    logic start_en;
    logic hardware_arm_input_en;
    logic pol;
    logic toggle;
  } ctrsr_mode_t;

  // Acquisition and generation timing signals
  typedef struct packed {
    logic change_det;
    logic comparison;
    logic dig_out_sample_clock;
    logic dig_in_sample_clock;
    logic gen_sample_clock;
    logic acq_convert_clock;
    logic acq_sample_clock;
    logic acq_start_trigger;
    logic acq_reference_trigger;
  } ctrsr_timing_t;

  // Routed inputs presented to one count core
  typedef struct packed {
    logic gate;
    logic aux;
    logic a;
    logic b;
    logic z;
  } ctrsr_ctr_sig_t;
endpackage : ctrsr_pkg

// >>> logic/ctrsr_sel.sv
`include "ctrsr_defines.svh"

module ctrsr_sel #(
  parameter int NSRC = `CTRSR_NSRC,
  parameter logic [NSRC-1:0] MASK = '1
) (
  // Candidate sources
  input wire logic [NSRC-1:0] src,
  // Binary select code
  input wire ctrsr_pkg::ctrsr_code_t code,
  // Chosen level
  output logic sel
);
  always_comb begin
    sel = 1'b0;
    if (32'(code) < NSRC) begin
      sel = src[code] & MASK[code];
    end
  end
endmodule : ctrsr_sel

// >>> logic/ctrsr_top.sv
`include "ctrsr_defines.svh"

module ctrsr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Programmable function lines
  input wire logic [15:0] pfi_i,
  output logic [15:0] pfi_o,
  output logic [15:0] pfi_oe_n,
  // Sync trunk lines and star line
  input wire logic [7:0] trunk_i,
  output logic [7:0] trunk_o,
  output logic [7:0] trunk_oe_n,
  input wire logic star_i,
  // On-chip timing signals and square wave
  input wire ctrsr_pkg::ctrsr_timing_t timing_i,
  input wire logic square_wave_output_i,
  // Count cores
  input wire logic [1:0] ctr_src_i,
  input wire logic [1:0] terminal_count_i,
  output ctrsr_pkg::ctrsr_ctr_sig_t [1:0] ctr_sig_o,
  output logic [1:0] count_en_o,
  output logic [1:0] armed_o,
  output logic [1:0] int_out_o,
  // Square wave to digital sample clocks
  output logic dig_in_clk_o,
  output logic dig_out_clk_o
);
  localparam logic [`CTRSR_NSRC-1:0] MASKS [6] = '{`CTRSR_MASK_GATE, `CTRSR_MASK_AUX,
    `CTRSR_MASK_ARM, `CTRSR_MASK_ABZ, `CTRSR_MASK_ABZ, `CTRSR_MASK_ABZ};

  logic [15:0] pfi_s1_q, pfi_s2_q;
  logic [7:0] trunk_s1_q, trunk_s2_q;
  logic star_s1_q, star_s2_q;
  ctrsr_pkg::ctrsr_code_t code_q [2][6];
  ctrsr_pkg::ctrsr_mode_t mode_q [2];
  logic [31:0] cnt_q [2];
  logic [31:0] pulses_q [2];
  ctrsr_pkg::ctrsr_route_t pfi_rt_q [16];
  ctrsr_pkg::ctrsr_route_t trunk_rt_q [8];
  logic [1:0] sqw_rt_q;
  logic [5:0] sel_d [2];
  logic [5:0] sel_q [2];
  logic [1:0] arm_prev_q, gate_prev_q, armed_q, armed_prev_q, run_q, done_q, tog_q;
  logic [1:0] arm_rise, gate_rise, start_go, pause_act, tc_ok, arm_cmd, disarm_cmd;
  logic [7:0] rt_vec;
  logic [7:0] trunk_vec;

  // Pin inputs pass two flip-flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pfi_s1_q <= 16'h0;
      pfi_s2_q <= 16'h0;
      trunk_s1_q <= 8'h0;
      trunk_s2_q <= 8'h0;
      star_s1_q <= 1'b0;
      star_s2_q <= 1'b0;
    end else begin
      pfi_s1_q <= pfi_i;
      pfi_s2_q <= pfi_s1_q;
      trunk_s1_q <= trunk_i;
      trunk_s2_q <= trunk_s1_q;
      star_s1_q <= star_i;
      star_s2_q <= star_s1_q;
    end
  end

  assign arm_cmd = (wr_i && addr_i == `CTRSR_REG_CMD) ? wdata_i[`CTRSR_CMD_ARM +: 2] : 2'h0;
  assign disarm_cmd = (wr_i && addr_i == `CTRSR_REG_CMD) ?
    wdata_i[`CTRSR_CMD_DISARM +: 2] : 2'h0;

  for (genvar i = 0; i < 2; i++) begin : g_ctr
    logic [`CTRSR_NSRC-1:0] src;
    // Source vector: trunk, function lines, timing, star, events, other counter, own gate
    assign src = {sel_q[i][0], sel_q[1-i][0], ctr_src_i[1-i], int_out_o[1-i],
      timing_i.comparison, timing_i.change_det, star_s2_q,
      timing_i.dig_out_sample_clock, timing_i.dig_in_sample_clock,
      timing_i.gen_sample_clock, timing_i.acq_convert_clock, timing_i.acq_sample_clock,
      timing_i.acq_start_trigger, timing_i.acq_reference_trigger, pfi_s2_q, trunk_s2_q};

    // Selectors: gate, aux, hardware arm, A, B, Z
    for (genvar j = 0; j < 6; j++) begin : g_sel
      ctrsr_sel #(
        .NSRC(`CTRSR_NSRC),
        .MASK(MASKS[j])
      ) u_sel (
        .src(src),
        .code(code_q[i][j]),
        .sel(sel_d[i][j])
      );

      always_ff @(posedge clk) begin
        if (!nrst) begin
          code_q[i][j] <= 6'h3f;
        end else if (wr_i && addr_i == 4'(i * `CTRSR_CTR_STRIDE + j / 3)) begin
          code_q[i][j] <= wdata_i[(j % 3) * `CTRSR_SEL_FIELD +: `CTRSR_CODE_W];
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        mode_q[i] <= `CTRSR_RST_MODE;
        cnt_q[i] <= `CTRSR_RST_CNT;
      end else begin
        if (wr_i && addr_i == 4'(i * `CTRSR_CTR_STRIDE + `CTRSR_REG_MODE)) begin
          mode_q[i] <= wdata_i[7:0];
        end
        if (wr_i && addr_i == 4'(i * `CTRSR_CTR_STRIDE + `CTRSR_REG_CNT)) begin
          cnt_q[i] <= wdata_i;
        end
      end
    end

    assign arm_rise[i] = sel_q[i][2] & ~arm_prev_q[i];
    assign gate_rise[i] = sel_q[i][0] & ~gate_prev_q[i];
    // Start comes from the gate when enabled, else from the arm event
    assign start_go[i] = mode_q[i].start_en ?
      (gate_rise[i] & ~run_q[i] & (~done_q[i] | mode_q[i].retrig)) :
      (armed_q[i] & ~armed_prev_q[i]);
    assign pause_act[i] = mode_q[i].pause_en & ~mode_q[i].start_en &
      (sel_q[i][0] == mode_q[i].pause_level);
    assign tc_ok[i] = terminal_count_i[i] & count_en_o[i];

    // Registered selections and arm state
    always_ff @(posedge clk) begin
      if (!nrst) begin
        sel_q[i] <= 6'h0;
        arm_prev_q[i] <= 1'b0;
        gate_prev_q[i] <= 1'b0;
        armed_q[i] <= 1'b0;
        armed_prev_q[i] <= 1'b0;
      end else begin
        sel_q[i] <= sel_d[i];
        arm_prev_q[i] <= sel_q[i][2];
        gate_prev_q[i] <= sel_q[i][0];
        armed_prev_q[i] <= armed_q[i];
        if (disarm_cmd[i]) begin
          armed_q[i] <= 1'b0;
        end else if (arm_cmd[i] || (mode_q[i].hardware_arm_input_en && arm_rise[i])) begin
          armed_q[i] <= 1'b1;
        end
      end
    end

    // Run control: continuous until disarm, finite until count
    always_ff @(posedge clk) begin
      if (!nrst) begin
        run_q[i] <= 1'b0;
        done_q[i] <= 1'b0;
        pulses_q[i] <= 32'h0;
      end else if (!armed_q[i]) begin
        run_q[i] <= 1'b0;
        done_q[i] <= 1'b0;
        pulses_q[i] <= 32'h0;
      end else if (start_go[i]) begin
        run_q[i] <= 1'b1;
        done_q[i] <= 1'b0;
        pulses_q[i] <= 32'h0;
      end else if (run_q[i] && tc_ok[i]) begin
        pulses_q[i] <= pulses_q[i] + 32'h1;
        if (mode_q[i].finite && pulses_q[i] + 32'h1 >= cnt_q[i]) begin
          run_q[i] <= 1'b0;
          done_q[i] <= 1'b1;
        end
      end
    end

    // Core-facing signals, quiet until armed
    always_ff @(posedge clk) begin
      if (!nrst) begin
        ctr_sig_o[i] <= '0;
        count_en_o[i] <= 1'b0;
        armed_o[i] <= 1'b0;
      end else begin
        ctr_sig_o[i].gate <= armed_q[i] & sel_q[i][0];
        ctr_sig_o[i].aux <= armed_q[i] & sel_q[i][1];
        ctr_sig_o[i].a <= armed_q[i] & sel_q[i][3];
        ctr_sig_o[i].b <= armed_q[i] & sel_q[i][4];
        ctr_sig_o[i].z <= armed_q[i] & sel_q[i][5];
        count_en_o[i] <= armed_q[i] & run_q[i] & ~pause_act[i];
        armed_o[i] <= armed_q[i];
      end
    end

    // Internal output stage
    always_ff @(posedge clk) begin
      if (!nrst) begin
        tog_q[i] <= 1'b0;
        int_out_o[i] <= 1'b0;
      end else if (!armed_q[i]) begin
        tog_q[i] <= 1'b0;
        int_out_o[i] <= mode_q[i].pol;
      end else begin
        tog_q[i] <= tog_q[i] ^ tc_ok[i];
        int_out_o[i] <= mode_q[i].pol ^ (mode_q[i].toggle ?
          (tog_q[i] ^ tc_ok[i]) : tc_ok[i]);
      end
    end

    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!nrst)
      !armed_q[i] |=> !ctr_sig_o[i].gate && !count_en_o[i] && !ctr_sig_o[i].b)
      else $error("io active while disarmed");
    AST_HARDWARE_ARM_INPUT: assert property (@(posedge clk) disable iff (!nrst)
      mode_q[i].hardware_arm_input_en && arm_rise[i] && !disarm_cmd[i] |=> ##1 armed_o[i])
      else $error("hardware arm edge not taken");
    AST_PULSE_OUT: assert property (@(posedge clk) disable iff (!nrst)
      armed_q[i] && !mode_q[i].toggle && tc_ok[i] |=> int_out_o[i] == !$past(mode_q[i].pol))
      else $error("no pulse on terminal count");
    AST_TOGGLE_OUT: assert property (@(posedge clk) disable iff (!nrst)
      armed_q[i] && mode_q[i].toggle && tc_ok[i] && $stable(mode_q[i]) && $past(armed_q[i])
      |=> int_out_o[i] != $past(int_out_o[i]))
      else $error("no toggle on terminal count");
    AST_IDLE_POL: assert property (@(posedge clk) disable iff (!nrst)
      !armed_q[i] ##1 !armed_q[i] |-> int_out_o[i] == $past(mode_q[i].pol))
      else $error("idle level ignores polarity");
    AST_FINITE_END: assert property (@(posedge clk) disable iff (!nrst)
      armed_q[i] && !start_go[i] && run_q[i] && mode_q[i].finite && tc_ok[i] &&
      pulses_q[i] + 32'h1 >= cnt_q[i] |=> !run_q[i] && done_q[i] ##1 !count_en_o[i])
      else $error("finite generation overran count");
    AST_RETRIGGER: assert property (@(posedge clk) disable iff (!nrst)
      armed_q[i] && done_q[i] && mode_q[i].start_en && mode_q[i].retrig && gate_rise[i]
      |=> run_q[i] && pulses_q[i] == 32'h0)
      else $error("retrigger did not restart");
    AST_NO_RETRIG: assert property (@(posedge clk) disable iff (!nrst)
      armed_q[i] && done_q[i] && mode_q[i].start_en && !mode_q[i].retrig |=> !run_q[i])
      else $error("finite generation restarted");
    AST_PAUSE: assert property (@(posedge clk) disable iff (!nrst)
      armed_q[i] && pause_act[i] |=> !count_en_o[i])
      else $error("counting during pause");
    AST_PAUSE_EXCL: assert property (@(posedge clk) disable iff (!nrst)
      mode_q[i].start_en && armed_q[i] && run_q[i] |=> count_en_o[i])
      else $error("gate paused while used as start");
    AST_RESERVED: assert property (@(posedge clk) disable iff (!nrst)
      code_q[i][0] >= 6'(`CTRSR_NSRC) |=> !sel_q[i][0])
      else $error("reserved gate code not low");
    COV_FINITE: cover property (@(posedge clk) disable iff (!nrst)
      run_q[i] && mode_q[i].finite ##1 done_q[i]);
    COV_RETRIG: cover property (@(posedge clk) disable iff (!nrst)
      done_q[i] ##1 run_q[i]);
    COV_PAUSE: cover property (@(posedge clk) disable iff (!nrst)
      run_q[i] && pause_act[i] ##1 run_q[i] && !pause_act[i]);
    COV_TOGGLE: cover property (@(posedge clk) disable iff (!nrst)
      mode_q[i].toggle && tc_ok[i]);
  end

  // Route sources: off, gates, internal outputs, square wave / Z
  assign rt_vec = {2'b00, square_wave_output_i, int_out_o[1], int_out_o[0], sel_q[1][0],
    sel_q[0][0], 1'b0};
  assign trunk_vec = {1'b0, sel_q[1][5], sel_q[0][5], int_out_o[1], int_out_o[0],
    sel_q[1][0], sel_q[0][0], 1'b0};

  for (genvar k = 0; k < 16; k++) begin : g_pfi
    always_ff @(posedge clk) begin
      if (!nrst) begin
        pfi_rt_q[k] <= `CTRSR_RT_OFF;
      end else if (wr_i && addr_i == 4'(`CTRSR_REG_PFI_LO + k / 8)) begin
        pfi_rt_q[k] <= wdata_i[(k % 8) * 4 +: `CTRSR_ROUTE_W];
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        pfi_o[k] <= 1'b0;
        pfi_oe_n[k] <= 1'b1;
      end else begin
        pfi_o[k] <= rt_vec[pfi_rt_q[k]];
        pfi_oe_n[k] <= !(pfi_rt_q[k] != `CTRSR_RT_OFF && pfi_rt_q[k] <= `CTRSR_RT_SQW);
      end
    end

    AST_PFI_HIZ: assert property (@(posedge clk) disable iff (!nrst)
      pfi_rt_q[k] == `CTRSR_RT_OFF |=> pfi_oe_n[k])
      else $error("function line driven without route");
  end

  for (genvar k = 0; k < 8; k++) begin : g_trunk
    always_ff @(posedge clk) begin
      if (!nrst) begin
        trunk_rt_q[k] <= `CTRSR_RT_OFF;
      end else if (wr_i && addr_i == `CTRSR_REG_TRUNK) begin
        trunk_rt_q[k] <= wdata_i[k * 4 +: `CTRSR_ROUTE_W];
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        trunk_o[k] <= 1'b0;
        trunk_oe_n[k] <= 1'b1;
      end else begin
        trunk_o[k] <= trunk_vec[trunk_rt_q[k]];
        trunk_oe_n[k] <= !(trunk_rt_q[k] != `CTRSR_RT_OFF && trunk_rt_q[k] != 3'h7);
      end
    end
  end

  // Square wave to digital sample clocks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sqw_rt_q <= 2'h0;
      dig_in_clk_o <= 1'b0;
      dig_out_clk_o <= 1'b0;
    end else begin
      if (wr_i && addr_i == `CTRSR_REG_SQW) begin
        sqw_rt_q <= wdata_i[1:0];
      end
      dig_in_clk_o <= sqw_rt_q[0] & square_wave_output_i;
      dig_out_clk_o <= sqw_rt_q[1] & square_wave_output_i;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      rdata_o <= 32'h0;
      for (int i = 0; i < 2; i++) begin
        for (int j = 0; j < 6; j++) begin
          if (addr_i == 4'(i * `CTRSR_CTR_STRIDE + j / 3)) begin
            rdata_o[(j % 3) * `CTRSR_SEL_FIELD +: `CTRSR_CODE_W] <= code_q[i][j];
          end
        end
        if (addr_i == 4'(i * `CTRSR_CTR_STRIDE + `CTRSR_REG_MODE)) begin
          rdata_o[7:0] <= mode_q[i];
        end
        if (addr_i == 4'(i * `CTRSR_CTR_STRIDE + `CTRSR_REG_CNT)) begin
          rdata_o <= cnt_q[i];
        end
      end
      for (int k = 0; k < 16; k++) begin
        if (addr_i == 4'(`CTRSR_REG_PFI_LO + k / 8)) begin
          rdata_o[(k % 8) * 4 +: `CTRSR_ROUTE_W] <= pfi_rt_q[k];
        end
      end
      for (int k = 0; k < 8; k++) begin
        if (addr_i == `CTRSR_REG_TRUNK) begin
          rdata_o[k * 4 +: `CTRSR_ROUTE_W] <= trunk_rt_q[k];
        end
      end
      if (addr_i == `CTRSR_REG_STATUS) begin
        rdata_o[7:0] <= {2'h0, done_q, run_q, armed_q};
      end
      if (addr_i == `CTRSR_REG_SQW) begin
        rdata_o[1:0] <= sqw_rt_q;
      end
    end
  end
endmodule : ctrsr_top

// >>> tb/ctrsr_far_model.sv
module ctrsr_far_model (
  // Far-side drive values
  input wire logic [15:0] ext_pfi,
  input wire logic [7:0] ext_trunk,
  // Device pin drive
  input wire logic [15:0] pfi_o,
  input wire logic [15:0] pfi_oe_n,
  input wire logic [7:0] trunk_o,
  input wire logic [7:0] trunk_oe_n,
  // Resolved line levels
  output logic [15:0] pfi_i,
  output logic [7:0] trunk_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Far side lets go of a line while the device drives it
  always_comb begin
    pfi_i = (pfi_o & ~pfi_oe_n) | (ext_pfi & pfi_oe_n);
    trunk_i = (trunk_o & ~trunk_oe_n) | (ext_trunk & trunk_oe_n);
  end
endmodule : ctrsr_far_model

// >>> tb/ctrsr_tb_top.sv
module ctrsr_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] ext_pfi = 16'h0;
  logic [15:0] pfi_i, pfi_o, pfi_oe_n;
  logic [7:0] ext_trunk = 8'h0;
  logic [7:0] trunk_i, trunk_o, trunk_oe_n;
  logic star = 1'b0;
  logic sq = 1'b0;
  logic [8:0] tmg = 9'h0;
  logic [1:0] csrc = 2'h0;
  logic [1:0] tc = 2'h0;
  logic [1:0] count_en, armed, int_out;
  ctrsr_pkg::ctrsr_ctr_sig_t [1:0] ctr_sig;
  logic dig_in_clk, dig_out_clk;
  logic [31:0] seed = 32'h0001_6cdf;
  logic [31:0] d;
  logic [37:0] m;
  logic v;
  logic b;
  int mismatches = 0;
  int n_tests = 0;

  always #25 clk = ~clk;

  ctrsr_far_model u_ctrsr_far_model (.ext_pfi(ext_pfi), .ext_trunk(ext_trunk), .pfi_o(pfi_o),
    .pfi_oe_n(pfi_oe_n), .trunk_o(trunk_o), .trunk_oe_n(trunk_oe_n), .pfi_i(pfi_i),
    .trunk_i(trunk_i));

  ctrsr_top u_ctrsr_top (.clk(clk), .nrst(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .pfi_i(pfi_i), .pfi_o(pfi_o), .pfi_oe_n(pfi_oe_n),
    .trunk_i(trunk_i), .trunk_o(trunk_o), .trunk_oe_n(trunk_oe_n), .star_i(star),
    .timing_i(ctrsr_pkg::ctrsr_timing_t'(tmg)), .square_wave_output_i(sq), .ctr_src_i(csrc),
    .terminal_count_i(tc), .ctr_sig_o(ctr_sig), .count_en_o(count_en), .armed_o(armed),
    .int_out_o(int_out), .dig_in_clk_o(dig_in_clk), .dig_out_clk_o(dig_out_clk));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Source vector in select-code order; other counter gate is star, its output high
  function automatic logic [37:0] src_vec();
    return {1'b0, star, csrc[1], 1'b1, tmg[7], tmg[8], star, tmg[6:0], ext_pfi, ext_trunk};
  endfunction : src_vec

  function automatic logic exp_sel(input int c, input logic [37:0] msk);
    logic [37:0] s;
    s = src_vec();
    return (c < 38 && msk[c]) ? s[c] : 1'b0;
  endfunction : exp_sel

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] val);
    @(posedge clk);
    addr <= a;
    wdata <= val;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] val);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    val = rdata;
  endtask : rd_reg

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic tc_pulse();
    @(posedge clk);
    tc <= 2'b01;
    @(posedge clk);
    tc <= 2'b00;
  endtask : tc_pulse

  task automatic rnd_src();
    logic [31:0] r;
    r = xs();
    ext_pfi <= r[15:0];
    ext_trunk <= r[23:16];
    star <= r[24];
    csrc <= r[26:25];
    r = xs();
    tmg <= r[8:0];
  endtask : rnd_src

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    chk("pfi_oe_n", pfi_oe_n, 32'hffff);
    chk("trunk_oe_n", trunk_oe_n, 32'hff);
    rd_reg(4'h2, d);
    chk("mode0", d, 32'h0);
    rd_reg(4'h3, d);
    chk("count0", d, 32'h1);
    wr_reg(4'he, 32'hffff_ffff);
    rd_reg(4'he, d);
    chk("unmapped", d, 32'h0);
    $display("test reset done");
    // Selectors, codes 0 to 45 of the gate, aux, A, B and Z inputs
    wr_reg(4'h0, 32'h003f_3f1f);
    star <= 1'b1;
    cyc(6);
    chk("unarmed sig", ctr_sig[0], 32'h0);
    wr_reg(4'h4, 32'h003f_3f1f);
    wr_reg(4'h6, 32'h2);
    wr_reg(4'hb, 32'h1);
    for (int k = 0; k < 5; k++) begin
      m = (k == 0) ? 38'h0f_ffff_ffff : (k == 1) ? 38'h3e_83ff_ffff : 38'h02_80ff_ffff;
      for (int c = 0; c < 46; c++) begin
        wr_reg((k > 1) ? 4'h1 : 4'h0, (32'h003f_3f3f & ~(32'h3f << (8 * (k % 2 + k / 4 * 2))))
          | (32'(c) << (8 * (k % 2 + k / 4 * 2))));
        wr_reg((k > 1) ? 4'h0 : 4'h1, 32'h003f_3f3f);
        rnd_src();
        cyc(6);
        chk("selected", ctr_sig[0][4-k], exp_sel(c, m));
      end
    end
    $display("test selectors done");
    // Output routes
    wr_reg(4'hb, 32'hc);
    wr_reg(4'h0, 32'h003f_3f1f);
    wr_reg(4'h1, 32'h001f_3f3f);
    wr_reg(4'h8, 32'h0006_2531);
    wr_reg(4'ha, 32'h0000_7315);
    wr_reg(4'hd, 32'h3);
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      wr_reg(4'h2, v ? 32'h0 : 32'h2);
      star <= v;
      sq <= ~v;
      cyc(6);
      chk("pfi_oe_n", pfi_oe_n, 32'hfff0);
      chk("pfi_o", pfi_o[3:0], {v, ~v, ~v, v});
      chk("trunk", {trunk_oe_n, trunk_o[2:0]}, {8'hf8, ~v, v, v});
      chk("sample clocks", {dig_in_clk, dig_out_clk}, {~v, ~v});
    end
    $display("test routes done");
    // Software arm and terminal count output
    wr_reg(4'h2, 32'h0);
    wr_reg(4'hb, 32'h1);
    cyc(4);
    chk("armed", armed[0], 32'h1);
    chk("count_en", count_en[0], 32'h1);
    rd_reg(4'hc, d);
    chk("status armed", d[0], 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr_reg(4'h2, 32'(i));
      cyc(2);
      b = int_out[0];
      if (i % 2 == 0) chk("idle out", b, i / 2);
      tc_pulse();
      @(posedge clk);
      chk("out on tc", int_out[0], {~b});
      @(posedge clk);
      chk("out after tc", int_out[0], (i % 2) ? {~b} : {b});
    end
    $display("test output done");
    // Finite generation
    wr_reg(4'hb, 32'h4);
    wr_reg(4'h2, 32'h10);
    wr_reg(4'h3, 32'h2);
    wr_reg(4'hb, 32'h1);
    cyc(4);
    tc_pulse();
    cyc(2);
    chk("count_en mid", count_en[0], 32'h1);
    tc_pulse();
    cyc(4);
    chk("count_en end", count_en[0], 32'h0);
    rd_reg(4'hc, d);
    chk("status done", d & 32'h15, 32'h11);
    // Start trigger through gate, with and without retrigger
    for (int r = 1; r >= 0; r--) begin
      wr_reg(4'hb, 32'h4);
      wr_reg(4'h2, r ? 32'h38 : 32'h18);
      wr_reg(4'h3, 32'h1);
      star <= 1'b0;
      wr_reg(4'hb, 32'h1);
      cyc(6);
      chk("wait start", count_en[0], 32'h0);
      star <= 1'b1;
      cyc(6);
      chk("started", count_en[0], 32'h1);
      tc_pulse();
      cyc(4);
      chk("finished", count_en[0], 32'h0);
      star <= 1'b0;
      cyc(6);
      star <= 1'b1;
      cyc(6);
      chk("retrigger", count_en[0], r);
    end
    $display("test trigger done");
    // Pause at both levels, then ignored while gate starts
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      wr_reg(4'hb, 32'h4);
      wr_reg(4'h2, v ? 32'hc0 : 32'h40);
      star <= ~v;
      wr_reg(4'hb, 32'h1);
      cyc(6);
      chk("not paused", count_en[0], 32'h1);
      star <= v;
      cyc(6);
      chk("paused", count_en[0], 32'h0);
    end
    wr_reg(4'hb, 32'h4);
    wr_reg(4'h2, 32'hc8);
    star <= 1'b0;
    wr_reg(4'hb, 32'h1);
    cyc(4);
    star <= 1'b1;
    cyc(6);
    chk("start not pause", count_en[0], 32'h1);
    $display("test pause done");
    // Hardware arm of counter 1 from counter 0 output
    wr_reg(4'hb, 32'hc);
    wr_reg(4'h2, 32'h0);
    wr_reg(4'h4, 32'h0022_3f3f);
    wr_reg(4'h6, 32'h4);
    cyc(6);
    chk("hw unarmed", armed[1], 32'h0);
    wr_reg(4'h2, 32'h2);
    cyc(6);
    chk("hw armed", armed[1], 32'h1);
    $display("test hardware_arm_input done");
    stop_test();
  end
endmodule : ctrsr_tb_top
